// file: hdl/bccab_defines.svh
// Offsets, field positions, reset values and timing counts of the byte count compare block.
`ifndef BCCAB_DEFINES_SVH
`define BCCAB_DEFINES_SVH
`define BCCAB_CTRL_OFS        4'h0
`define BCCAB_STAT_OFS        4'h4
`define BCCAB_CTRL_RST        3'h0
`define BCCAB_CTRL_WRITE      0
`define BCCAB_CTRL_CHAIN      1
`define BCCAB_CTRL_CLEAR      2
`define BCCAB_ST_TRIG         0
`define BCCAB_ST_MATCH        1
`define BCCAB_ST_ZERO         2
`define BCCAB_ST_GREATER      3
`define BCCAB_ST_CHKCHAIN     4
`define BCCAB_ST_OVERRUN      5
`define BCCAB_ST_MARK         8
`define BCCAB_NEW_COUNT_MIN   8
`define BCCAB_CLK_NS          4
`define BCCAB_PULSE_NS        100
`define BCCAB_PULSE_CYC       ((`BCCAB_PULSE_NS) / (`BCCAB_CLK_NS))
`define BCCAB_RESP_OKAY       2'h0
`define BCCAB_RESP_SLVERR     2'h2
`endif

// file: hdl/bccab_pkg.sv
// Types shared by the byte count compare block.
package bccab_pkg;
	typedef enum logic [1:0] {
		BCCAB_IDLE  = 2'h0,
		BCCAB_PULSE = 2'h1,
		BCCAB_HOLD  = 2'h3
	} bccab_pulse_e;
	typedef logic [7:0] bccab_byte_t;
endpackage

// file: hdl/bccab_buffer.sv
// Eight-byte assembly and disassembly buffer with inverted parity storage.
`timescale 1ns/1ps
module bccab_buffer
	import bccab_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        buf_reset,
	input  wire logic        stage_load,
	input  wire logic [63:0] stage_data,
	input  wire logic [7:0]  stage_par_n,
	input  wire logic [7:0]  gate_in_byte,
	input  wire logic [7:0]  bus_in_data,
	input  wire logic        bus_in_par_n,
	output logic      [63:0] buf_data,
	output logic      [7:0]  buf_par_n
);
	logic [63:0] data_r;
	logic [63:0] data_nxt;
	logic [7:0]  par_r;
	logic [7:0]  par_nxt;

	// Byte 0 occupies bits 63:56, byte 7 bits 7:0.
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_lane
			always_comb begin
				data_nxt[63-8*i -: 8] = data_r[63-8*i -: 8];
				par_nxt[7-i] = par_r[7-i];
				if (buf_reset) begin
					data_nxt[63-8*i -: 8] = 8'h00;
					par_nxt[7-i] = 1'b1;
				end else if (stage_load) begin
					data_nxt[63-8*i -: 8] = stage_data[63-8*i -: 8];
					par_nxt[7-i] = stage_par_n[7-i];
				end else if (gate_in_byte[i]) begin
					data_nxt[63-8*i -: 8] = bus_in_data;
					par_nxt[7-i] = bus_in_par_n;
				end
			end
		end
	endgenerate

	// Data latches are high for a one, parity latches low for a one.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_r <= 64'h0000000000000000;
			par_r  <= 8'hFF;
		end else begin
			data_r <= data_nxt;
			par_r  <= par_nxt;
		end
	end

	assign buf_data  = data_r;
	assign buf_par_n = par_r;
endmodule

// file: hdl/bccab_top.sv
// Byte count compare logic with its assembly buffer and an AXI4-Lite control slave.
// Summary of operation
// - Compare count bits 21-23 with byte counter.
// - Strobe sets match trigger when last word.
// - Evaluate on byte loads and byte removals.
// - Match trigger sets the holding match latch.
// - Write match gives one 100 ns reset pulse.
// - Chained write match starts next command fetch.
// - Trigger or zero latch: full / sequence 3.
// - Match latch without chaining starts sequence 5.
// - Match latch on read stops count decrement.
// - Match latch feeds status for length check.
// - Chained write compares old count in mark.
// - Zero latch sets when counter reads zero.
// - Zero latch on write drops buffer full.
// - Zero latch detects chained read overrun.
// - Zero latch logged at bit 18, word 3.
// - Greater with new count under 8: check.
// - Buffer holds 64 data, 8 parity latches.
// - Data latch high, parity latch low, active.
// - Read bytes load at encoder-selected positions.
// - Write bytes leave one at a time.
// - Staging load: reset buffer, then transfer.
// - Buffer copied whole to staging on read.
// - Parity passes through without any checking.
// - Counter output equals count register plus one.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "bccab_defines.svh"
module bccab_top
	import bccab_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [2:0]  transfer_count_register,
	input  wire logic [2:0]  byte_count_value,
	input  wire logic        last_word,
	input  wire logic        compare_strobe,
	input  wire logic        mark_load,
	input  wire logic        command_word_fetching,
	input  wire logic [3:0]  new_count_bytes,
	input  wire logic        log_gate,
	input  wire logic        buf_reset,
	input  wire logic        stage_load,
	input  wire logic [63:0] storage_output_lines,
	input  wire logic [7:0]  storage_par_n,
	input  wire logic        buf_to_stage,
	input  wire logic [7:0]  gate_in_byte,
	input  wire logic [7:0]  gate_out_byte,
	input  wire logic [7:0]  bus_in_data,
	input  wire logic        bus_in_par_n,
	output logic      [2:0]  byte_counter_outputs,
	output logic             count_match_trig,
	output logic             count_match_latch,
	output logic             zero_count_latch,
	output logic             full_or_seq3,
	output logic             seq5_start,
	output logic             decrement_inhibit,
	output logic             wr_equal_reset,
	output logic             chain_fetch_start,
	output logic             buf_full_off,
	output logic             overrun,
	output logic             chain_check,
	output logic             log_bit18,
	output logic      [63:0] stage_data,
	output logic      [7:0]  stage_par_n,
	output logic      [7:0]  bus_out_data,
	output logic             bus_out_par_n
);
	localparam logic [4:0] PULSE_CYC = 5'(`BCCAB_PULSE_CYC);

	logic [2:0]   ctrl_r;
	logic [2:0]   ctrl_nxt;
	logic         clear_r;
	logic         clear_nxt;
	logic         awready_r;
	logic         awready_nxt;
	logic         wready_r;
	logic         wready_nxt;
	logic         bvalid_r;
	logic         bvalid_nxt;
	logic [1:0]   bresp_r;
	logic [1:0]   bresp_nxt;
	logic         arready_r;
	logic         arready_nxt;
	logic         rvalid_r;
	logic         rvalid_nxt;
	logic [1:0]   rresp_r;
	logic [1:0]   rresp_nxt;
	logic [31:0]  rdata_r;
	logic [31:0]  rdata_nxt;
	logic         wr_take;
	logic         rd_take;
	logic [31:0]  status_word;

	logic         op_write;
	logic         data_chaining_flag;
	logic         chained_write;
	logic         chained_read;
	logic [2:0]   cnt_out;
	logic [2:0]   mark_r;
	logic [2:0]   mark_nxt;
	logic         count_equal;
	logic         mark_equal;
	logic         greater;
	logic         trig_r;
	logic         trig_nxt;
	logic         match_r;
	logic         match_nxt;
	logic         zero_r;
	logic         zero_nxt;
	logic         overrun_r;
	logic         overrun_nxt;
	logic         chk_r;
	logic         chk_nxt;
	logic         seq5_r;
	logic         seq5_nxt;
	logic         fetch_r;
	logic         fetch_nxt;
	logic         full3_r;
	logic         full3_nxt;
	logic         inhibit_r;
	logic         inhibit_nxt;
	logic         bfoff_r;
	logic         bfoff_nxt;
	logic         log_r;
	logic         log_nxt;
	logic [2:0]   cnt_out_r;
	bccab_pulse_e pstate_r;
	bccab_pulse_e pstate_nxt;
	logic [4:0]   pcnt_r;
	logic [4:0]   pcnt_nxt;
	logic         pulse_r;
	logic         pulse_nxt;
	logic [63:0]  buf_data;
	logic [7:0]   buf_par_n;
	logic [63:0]  stage_r;
	logic [63:0]  stage_nxt;
	logic [7:0]   spar_r;
	logic [7:0]   spar_nxt;
	logic [7:0]   out_r;
	logic [7:0]   out_nxt;
	logic         opar_r;
	logic         opar_nxt;

	assign op_write           = ctrl_r[`BCCAB_CTRL_WRITE];
	assign data_chaining_flag = ctrl_r[`BCCAB_CTRL_CHAIN];
	assign chained_write      = op_write & data_chaining_flag;
	assign chained_read       = ~op_write & data_chaining_flag;
	assign wr_take            = s_axi_awvalid & s_axi_wvalid & ~bvalid_r & ~awready_r;
	assign rd_take            = s_axi_arvalid & ~rvalid_r & ~arready_r;

	assign status_word = {20'h00000, 1'b0, mark_r, 2'h0, chk_r, overrun_r, greater, zero_r, match_r, trig_r};

	// Register slave: control at one word, read-only status at the next.
	always_comb begin
		ctrl_nxt    = ctrl_r;
		clear_nxt   = 1'b0;
		awready_nxt = wr_take;
		wready_nxt  = wr_take;
		bvalid_nxt  = bvalid_r & ~s_axi_bready;
		bresp_nxt   = bresp_r;
		arready_nxt = rd_take;
		rvalid_nxt  = rvalid_r & ~s_axi_rready;
		rresp_nxt   = rresp_r;
		rdata_nxt   = rdata_r;
		if (wr_take) begin
			bvalid_nxt = 1'b1;
			bresp_nxt  = `BCCAB_RESP_OKAY;
			if (s_axi_awaddr[3:2] == `BCCAB_CTRL_OFS >> 2) begin
				if (s_axi_wstrb[0]) begin
					ctrl_nxt  = {1'b0, s_axi_wdata[`BCCAB_CTRL_CHAIN], s_axi_wdata[`BCCAB_CTRL_WRITE]};
					clear_nxt = s_axi_wdata[`BCCAB_CTRL_CLEAR];
				end
			end else if (s_axi_awaddr[3:2] != `BCCAB_STAT_OFS >> 2) begin
				bresp_nxt = `BCCAB_RESP_SLVERR;
			end
		end
		if (rd_take) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = `BCCAB_RESP_OKAY;
			if (s_axi_araddr[3:2] == `BCCAB_CTRL_OFS >> 2) begin
				rdata_nxt = {29'h00000000, ctrl_r};
			end else if (s_axi_araddr[3:2] == `BCCAB_STAT_OFS >> 2) begin
				rdata_nxt = status_word;
			end else begin
				rdata_nxt = 32'h00000000;
				rresp_nxt = `BCCAB_RESP_SLVERR;
			end
		end
	end

	// Counter output is the count register plus one.
	assign cnt_out = byte_count_value + 3'h1;

	// Bitwise equality of count bits 21-23 against the counter outputs.
	assign count_equal = (transfer_count_register ~^ cnt_out) == 3'h7;
	assign mark_equal  = (mark_r ~^ cnt_out) == 3'h7;
	assign greater     = cnt_out > transfer_count_register;

	// Compare triggers, latches and pulse sequencer.
	always_comb begin
		mark_nxt    = mark_load & chained_write & command_word_fetching ? transfer_count_register : mark_r;
		trig_nxt    = trig_r & ~clear_r;
		// The strobe fires on each byte moved in (read) or out (write).
		if (compare_strobe & count_equal & last_word & ~chained_write) begin
			trig_nxt = 1'b1;
		end
		if (compare_strobe & mark_equal & chained_write & command_word_fetching) begin
			trig_nxt = 1'b1;
		end
		match_nxt   = trig_r | (match_r & ~clear_r);
		zero_nxt    = (cnt_out == 3'h0) | (zero_r & ~clear_r);
		full3_nxt   = trig_r | zero_r;
		seq5_nxt    = match_nxt & ~match_r & ~data_chaining_flag;
		fetch_nxt   = trig_nxt & ~trig_r & chained_write;
		inhibit_nxt = match_r & ~op_write;
		bfoff_nxt   = zero_r & op_write;
		overrun_nxt = (zero_r & chained_read & command_word_fetching) | (overrun_r & ~clear_r);
		chk_nxt     = (greater & chained_read & command_word_fetching & new_count_bytes < `BCCAB_NEW_COUNT_MIN) |
			(chk_r & ~clear_r);
		log_nxt     = log_gate ? zero_r : log_r;
		pstate_nxt  = pstate_r;
		pcnt_nxt    = pcnt_r;
		pulse_nxt   = 1'b0;
		case (pstate_r)
			BCCAB_IDLE: begin
				if (trig_r & op_write) begin
					pstate_nxt = BCCAB_PULSE;
					pcnt_nxt   = PULSE_CYC - 5'h1;
					pulse_nxt  = 1'b1;
				end
			end
			BCCAB_PULSE: begin
				if (pcnt_r == 5'h0) begin
					pstate_nxt = BCCAB_HOLD;
				end else begin
					pcnt_nxt  = pcnt_r - 5'h1;
					pulse_nxt = 1'b1;
				end
			end
			BCCAB_HOLD: begin
				if (!trig_r) begin
					pstate_nxt = BCCAB_IDLE;
				end
			end
			default: begin
				pstate_nxt = BCCAB_IDLE;
			end
		endcase
	end

	// Staging copy and byte output path.
	always_comb begin
		stage_nxt = stage_r;
		spar_nxt  = spar_r;
		out_nxt   = out_r;
		opar_nxt  = opar_r;
		if (buf_to_stage & ~op_write) begin
			stage_nxt = buf_data;
			spar_nxt  = buf_par_n;
		end
		for (int k = 0; k < 8; k++) begin
			if (gate_out_byte[k] & op_write) begin
				out_nxt  = buf_data[63-8*k -: 8];
				opar_nxt = buf_par_n[7-k];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r    <= `BCCAB_CTRL_RST;
			clear_r   <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= 2'h0;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= 2'h0;
			rdata_r   <= 32'h00000000;
			mark_r    <= 3'h0;
			trig_r    <= 1'b0;
			match_r   <= 1'b0;
			zero_r    <= 1'b0;
			full3_r   <= 1'b0;
			seq5_r    <= 1'b0;
			fetch_r   <= 1'b0;
			inhibit_r <= 1'b0;
			bfoff_r   <= 1'b0;
			overrun_r <= 1'b0;
			chk_r     <= 1'b0;
			log_r     <= 1'b0;
			cnt_out_r <= 3'h0;
			pstate_r  <= BCCAB_IDLE;
			pcnt_r    <= 5'h0;
			pulse_r   <= 1'b0;
			stage_r   <= 64'h0000000000000000;
			spar_r    <= 8'hFF;
			out_r     <= 8'h00;
			opar_r    <= 1'b1;
		end else begin
			ctrl_r    <= ctrl_nxt;
			clear_r   <= clear_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
			mark_r    <= mark_nxt;
			trig_r    <= trig_nxt;
			match_r   <= match_nxt;
			zero_r    <= zero_nxt;
			full3_r   <= full3_nxt;
			seq5_r    <= seq5_nxt;
			fetch_r   <= fetch_nxt;
			inhibit_r <= inhibit_nxt;
			bfoff_r   <= bfoff_nxt;
			overrun_r <= overrun_nxt;
			chk_r     <= chk_nxt;
			log_r     <= log_nxt;
			cnt_out_r <= cnt_out;
			pstate_r  <= pstate_nxt;
			pcnt_r    <= pcnt_nxt;
			pulse_r   <= pulse_nxt;
			stage_r   <= stage_nxt;
			spar_r    <= spar_nxt;
			out_r     <= out_nxt;
			opar_r    <= opar_nxt;
		end
	end

	// The buffer holds 64 data and 8 parity latches.
	bccab_buffer u_buffer (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.buf_reset    (buf_reset),
		.stage_load   (stage_load & op_write),
		.stage_data   (storage_output_lines),
		.stage_par_n  (storage_par_n),
		.gate_in_byte (gate_in_byte & {8{~op_write}}),
		.bus_in_data  (bus_in_data),
		.bus_in_par_n (bus_in_par_n),
		.buf_data     (buf_data),
		.buf_par_n    (buf_par_n)
	);

	assign s_axi_awready        = awready_r;
	assign s_axi_wready         = wready_r;
	assign s_axi_bvalid         = bvalid_r;
	assign s_axi_bresp          = bresp_r;
	assign s_axi_arready        = arready_r;
	assign s_axi_rvalid         = rvalid_r;
	assign s_axi_rresp          = rresp_r;
	assign s_axi_rdata          = rdata_r;
	assign byte_counter_outputs = cnt_out_r;
	assign count_match_trig     = trig_r;
	assign count_match_latch    = match_r;
	assign zero_count_latch     = zero_r;
	assign full_or_seq3         = full3_r;
	assign seq5_start           = seq5_r;
	assign decrement_inhibit    = inhibit_r;
	assign wr_equal_reset       = pulse_r;
	assign chain_fetch_start    = fetch_r;
	assign buf_full_off         = bfoff_r;
	assign overrun              = overrun_r;
	assign chain_check          = chk_r;
	assign log_bit18            = log_r;
	assign stage_data           = stage_r;
	assign stage_par_n          = spar_r;
	assign bus_out_data         = out_r;
	assign bus_out_par_n        = opar_r;
endmodule

// file: verification/bccab_io_dev.sv
// Byte-wide I/O device model on the far side of the buffer.
`timescale 1ns/1ps
module bccab_io_dev
	import bccab_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       active,
	input  wire logic       adv,
	output logic      [7:0] bus_in_data,
	output logic            bus_in_par_n,
	input  wire logic [7:0] bus_out_data,
	output logic      [7:0] got
);
	logic [2:0] idx_r;
	logic [7:0] cur;
	assign cur = {1'b0, idx_r, 1'b0, idx_r};
	// Outside a transfer the bus shows the inverse of the next byte to be sent.
	assign bus_in_data = active ? cur : ~cur;
	assign bus_in_par_n = ^bus_in_data;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idx_r <= 3'h0;
			got <= 8'h00;
		end else if (adv) begin
			idx_r <= idx_r + 3'h1;
			got <= bus_out_data;
		end
	end
endmodule

// file: verification/bccab_props.sv
// Port-level checks of the byte count compare block.
`timescale 1ns/1ps
`include "bccab_defines.svh"
module bccab_props
	import bccab_pkg::*;
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [2:0] byte_count_value,
	input wire logic       compare_strobe,
	input wire logic       log_gate,
	input wire logic [2:0] byte_counter_outputs,
	input wire logic       count_match_trig,
	input wire logic       count_match_latch,
	input wire logic       zero_count_latch,
	input wire logic       full_or_seq3,
	input wire logic       seq5_start,
	input wire logic       decrement_inhibit,
	input wire logic       wr_equal_reset,
	input wire logic       chain_fetch_start,
	input wire logic       log_bit18
);
	logic [5:0] run_r;
	logic [5:0] run_nxt;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_comb begin
		run_nxt = wr_equal_reset ? run_r + 6'h01 : 6'h00;
	end
	always_ff @(posedge aclk) begin
		run_r <= aresetn ? run_nxt : 6'h00;
	end
	chk_trig_cause: assert property ($rose(count_match_trig) |-> $past(compare_strobe))
		else $error("match trigger without strobe");
	chk_trig_latch: assert property ($rose(count_match_trig) |=> count_match_latch)
		else $error("match latch not set");
	chk_full_or: assert property (full_or_seq3 == $past(count_match_trig || zero_count_latch))
		else $error("full or seq3 wrong");
	chk_seq5_pulse: assert property (seq5_start |-> count_match_latch ##1 !seq5_start)
		else $error("seq5 start wrong");
	chk_fetch_pulse: assert property (chain_fetch_start |-> count_match_trig ##1 !chain_fetch_start)
		else $error("chain fetch wrong");
	chk_pulse_len: assert property ($fell(wr_equal_reset) |-> run_r == 6'(`BCCAB_PULSE_CYC))
		else $error("reset pulse length wrong");
	chk_dec_inh: assert property (decrement_inhibit |-> count_match_latch || $past(count_match_latch))
		else $error("decrement inhibit without latch");
	chk_ctr_plus: assert property ($past(aresetn) |-> byte_counter_outputs == 3'($past(byte_count_value) + 3'h1))
		else $error("counter output wrong");
	chk_zero_set: assert property (byte_count_value == 3'h7 |=> zero_count_latch)
		else $error("zero latch not set");
	chk_log_zero: assert property (log_gate |=> log_bit18 == $past(zero_count_latch))
		else $error("log bit wrong");
	cover property (seq5_start);
	cover property (chain_fetch_start);
	cover property ($fell(wr_equal_reset));
endmodule
bind bccab_top bccab_props u_props (.aclk, .aresetn, .byte_count_value, .compare_strobe, .log_gate,
	.byte_counter_outputs, .count_match_trig, .count_match_latch, .zero_count_latch, .full_or_seq3,
	.seq5_start, .decrement_inhibit, .wr_equal_reset, .chain_fetch_start, .log_bit18);

// file: verification/bccab_tb.sv
// Self-checking bench for the byte count compare block.
`timescale 1ns/1ps
`include "bccab_defines.svh"
module bccab_tb
	import bccab_pkg::*;
	;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, new_count_bytes = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, last_word = 1'b0, compare_strobe = 1'b0, mark_load = 1'b0;
	logic        command_word_fetching = 1'b0, log_gate = 1'b0, buf_reset = 1'b0, stage_load = 1'b0;
	logic        buf_to_stage = 1'b0, io_act = 1'b0, io_adv = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [2:0]  transfer_count_register = 3'h7, byte_count_value = 3'h0, byte_counter_outputs;
	logic [63:0] storage_output_lines = 64'h0123456789ABCDEF, stage_data;
	logic [7:0]  storage_par_n = 8'h00, gate_in_byte = 8'h00, gate_out_byte = 8'h00;
	logic [7:0]  io_got, bus_in_data, bus_out_data, stage_par_n;
	logic        bus_in_par_n, bus_out_par_n, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, count_match_trig, count_match_latch, zero_count_latch, full_or_seq3;
	logic        seq5_start, decrement_inhibit, wr_equal_reset, chain_fetch_start, buf_full_off;
	logic        overrun, chain_check, log_bit18;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	int          n_fail = 0, check_count = 0, cyc = 0;
	bccab_top dut (.*);
	bccab_io_dev io (.aclk, .aresetn, .active(io_act), .adv(io_adv), .bus_in_data, .bus_in_par_n,
		.bus_out_data, .got(io_got));
	always #2 aclk = ~aclk;
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		tick(1);
	endtask
	task automatic axi_rd(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		tick(1);
	endtask
	task automatic ctl(input logic [2:0] v);
		axi_wr(`BCCAB_CTRL_OFS, {29'h0, v});
		tick(1);
	endtask
	task automatic strobe();
		compare_strobe <= 1'b1;
		tick(1);
		compare_strobe <= 1'b0;
		tick(3);
	endtask
	task automatic t_regs();
		axi_rd(`BCCAB_STAT_OFS);
		cmp(rd, 32'h0);
		ctl(3'h3);
		axi_rd(`BCCAB_CTRL_OFS);
		cmp(rd, 32'h3);
		axi_wr(4'h8, 32'h1);
		cmp(rsp, `BCCAB_RESP_SLVERR);
		axi_rd(4'hC);
		cmp({rsp, rd}, {`BCCAB_RESP_SLVERR, 32'h0});
		$display("regs done");
	endtask
	task automatic t_read();
		ctl(3'h4);
		transfer_count_register <= 3'h5;
		byte_count_value <= 3'h4;
		strobe();
		cmp(count_match_trig, 1'b0);
		last_word <= 1'b1;
		byte_count_value <= 3'h3;
		strobe();
		cmp(count_match_trig, 1'b0);
		byte_count_value <= 3'h4;
		strobe();
		cmp(byte_counter_outputs, 3'h5);
		cmp({count_match_trig, count_match_latch, full_or_seq3, decrement_inhibit}, 4'hF);
		axi_rd(`BCCAB_STAT_OFS);
		cmp(rd[1:0], 2'h3);
		$display("read match done");
	endtask
	task automatic t_write();
		// A clear while the trigger is on lets the latch set again, so the second clear empties it.
		ctl(3'h4);
		ctl(3'h5);
		cmp(count_match_latch, 1'b0);
		strobe();
		cmp(wr_equal_reset, 1'b1);
		tick(30);
		cmp({wr_equal_reset, count_match_latch}, 2'h1);
		$display("write match done");
	endtask
	task automatic t_chain();
		ctl(3'h7);
		command_word_fetching <= 1'b1;
		transfer_count_register <= 3'h2;
		mark_load <= 1'b1;
		tick(1);
		mark_load <= 1'b0;
		transfer_count_register <= 3'h6;
		byte_count_value <= 3'h1;
		strobe();
		cmp(count_match_trig, 1'b1);
		axi_rd(`BCCAB_STAT_OFS);
		cmp(rd[10:8], 3'h2);
		command_word_fetching <= 1'b0;
		$display("chained write done");
	endtask
	task automatic t_zero();
		ctl(3'h5);
		byte_count_value <= 3'h7;
		tick(3);
		cmp({zero_count_latch, buf_full_off}, 2'h3);
		log_gate <= 1'b1;
		tick(1);
		log_gate <= 1'b0;
		tick(2);
		cmp(log_bit18, 1'b1);
		ctl(3'h6);
		command_word_fetching <= 1'b1;
		tick(3);
		cmp(overrun, 1'b1);
		byte_count_value <= 3'h5;
		transfer_count_register <= 3'h2;
		new_count_bytes <= 4'h4;
		strobe();
		cmp(chain_check, 1'b1);
		$display("zero and chained read done");
	endtask
	task automatic t_buf();
		ctl(3'h4);
		buf_reset <= 1'b1;
		io_act <= 1'b1;
		tick(1);
		buf_reset <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			gate_in_byte <= 8'h01 << k;
			io_adv <= 1'b1;
			tick(1);
		end
		gate_in_byte <= 8'h00;
		io_adv <= 1'b0;
		io_act <= 1'b0;
		buf_to_stage <= 1'b1;
		tick(1);
		buf_to_stage <= 1'b0;
		tick(3);
		cmp({stage_par_n, stage_data}, {8'h00, 64'h0011223344556677});
		ctl(3'h5);
		buf_reset <= 1'b1;
		tick(1);
		buf_reset <= 1'b0;
		stage_load <= 1'b1;
		tick(1);
		stage_load <= 1'b0;
		gate_out_byte <= 8'h08;
		tick(1);
		gate_out_byte <= 8'h00;
		tick(2);
		cmp({bus_out_par_n, bus_out_data}, 9'h067);
		io_adv <= 1'b1;
		tick(1);
		io_adv <= 1'b0;
		tick(1);
		cmp(io_got, 8'h67);
		$display("buffer done");
	endtask
	task automatic print_verdict();
		$display("checks=%0d fails=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		tick(6);
		aresetn <= 1'b1;
		tick(1);
		t_regs();
		t_read();
		t_write();
		t_chain();
		t_zero();
		t_buf();
		print_verdict();
	end
endmodule
